// File: core/mbe_write_ctrl.sv
// Function
// - Address strobe fall latches full address
// - Shared lines carry address then data
// - Drive read data while phase, direction high
// - Write data taken on phase clock fall
// - Two 4K planes chosen by bit 12
// - Other plane stays readable during programming
// - Eight 1K sections with own permission
// - Section permissions held in their own register
// - Completion control input decides page programming
// - Pages of one to thirty-two bytes
// - Phase rise restarts load timer; expiry programs
// - Programming ends within 5 ms, pollable
// - Enable low, strobe low means standby
// - Decoder maps array into chosen region
// - Bit 6 alternates while plane programs
// - Guard blocks writes without three-byte command
`timescale 1ns/1ns
`default_nettype none

module mbe_write_ctrl
  import mbe_pkg::*;
#(
  parameter int LOAD_CYCLES = LOAD_WINDOW_CYCLES,
  parameter int PROG_TIME_CYCLES = PROG_CYCLES
) (
  // Clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  // Host bus
  input wire logic CHIP_ENABLE_IN,
  input wire logic ADDRESS_LATCH_STROBE_IN,
  input wire logic BUS_PHASE_CLK_IN,
  input wire logic READ_NOT_WRITE_IN,
  input wire logic [7:0] UPPER_ADDRESS_LINES_IN,
  input wire logic [7:0] SHARED_LOW_BUS_LINES_IN,
  output logic [7:0] SHARED_LOW_BUS_LINES_OUT,
  output logic SHARED_LOW_BUS_LINES_OE_OUT,
  // Write control and configuration
  input wire logic WRITE_COMPLETION_CONTROL_IN,
  input wire logic GLOBAL_WRITE_GUARD_IN,
  input wire logic [2:0] REGION_BASE_IN,
  // Status
  output logic STANDBY_OUT,
  output logic PROG_BUSY_OUT,
  output logic [7:0] SECTION_LOCK_OUT
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] section_of(input logic [12:0] a);
    return a[SECT_LO +: 3];
  endfunction

  function automatic logic [7:0] page_of(input logic [12:0] a);
    return a[MEM_AW-1:PAGE_AW];
  endfunction

  // ----------------------------------------------------------------
  // Bus sampling and address latch
  // ----------------------------------------------------------------
  logic as_prev_reg;
  logic e_prev_reg;
  logic sel_reg;
  mbe_addr_t addr_reg;
  logic as_fall, e_rise, e_fall, hit;
  logic wr_rise, wr_fall, rd_rise;

  assign as_fall = as_prev_reg & ~ADDRESS_LATCH_STROBE_IN;
  assign e_rise = ~e_prev_reg & BUS_PHASE_CLK_IN;
  assign e_fall = e_prev_reg & ~BUS_PHASE_CLK_IN;
  assign hit = sel_reg & (addr_reg.region == REGION_BASE_IN);
  assign wr_rise = e_rise & ~READ_NOT_WRITE_IN & hit;
  assign wr_fall = e_fall & ~READ_NOT_WRITE_IN & hit;
  assign rd_rise = e_rise & READ_NOT_WRITE_IN & hit;

  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      as_prev_reg <= 1'b0;
      e_prev_reg <= 1'b0;
    end else begin
      as_prev_reg <= ADDRESS_LATCH_STROBE_IN;
      e_prev_reg <= BUS_PHASE_CLK_IN;
    end
  end

  // Select is formed only if enable was up at the strobe fall
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      sel_reg <= 1'b0;
      addr_reg <= '0;
    end else if (as_fall) begin
      sel_reg <= CHIP_ENABLE_IN;
      addr_reg <= {UPPER_ADDRESS_LINES_IN, SHARED_LOW_BUS_LINES_IN};
    end
  end

  // ----------------------------------------------------------------
  // Array and page buffer
  // ----------------------------------------------------------------
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] page_data [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_valid_reg;
  logic [7:0] page_reg;
  logic [7:0] lock_reg;
  logic lock_open_reg;
  logic [1:0] seq_reg;
  logic prog_plane_reg;
  logic [TIMER_W-1:0] timer_reg;
  logic toggle_reg;
  mbe_state_t state_reg;
  logic guard_ok, sect_ok, page_ok, take_byte;
  logic start_prog, cancel, load_done;

  assign guard_ok = ~GLOBAL_WRITE_GUARD_IN | (seq_reg == SEQ_OPEN);
  assign sect_ok = ~lock_reg[section_of(addr_reg.offs)];
  assign page_ok = ~|page_valid_reg | (page_reg == page_of(addr_reg.offs));
  assign take_byte = wr_fall & (state_reg != ST_PROG) & guard_ok & ~lock_open_reg & sect_ok & page_ok;
  assign load_done = (state_reg == ST_LOAD) & (timer_reg == '0) & ~wr_rise;
  assign cancel = (state_reg == ST_LOAD) & WRITE_COMPLETION_CONTROL_IN;
  assign start_prog = load_done & ~cancel & |page_valid_reg;

  // Storage has no reset: the memory path ignores the system reset
  always_ff @(posedge CORE_CLK_IN) begin
    if (take_byte) begin
      page_data[addr_reg.offs[PAGE_AW-1:0]] <= SHARED_LOW_BUS_LINES_IN;
    end
    if (start_prog) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (page_valid_reg[i]) begin
          mem[{page_reg, i[PAGE_AW-1:0]}] <= page_data[i];
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      page_valid_reg <= '0;
      page_reg <= '0;
    end else if (cancel | load_done) begin
      page_valid_reg <= '0;
    end else if (take_byte) begin
      page_valid_reg[addr_reg.offs[PAGE_AW-1:0]] <= 1'b1;
      page_reg <= page_of(addr_reg.offs);
    end
  end

  // ----------------------------------------------------------------
  // Write guard command and section locks
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      seq_reg <= SEQ_IDLE;
      lock_open_reg <= 1'b0;
    end else if (cancel | load_done) begin
      seq_reg <= SEQ_IDLE;
      lock_open_reg <= 1'b0;
    end else if (wr_fall & (state_reg != ST_PROG)) begin
      if (lock_open_reg) begin
        lock_open_reg <= 1'b0;
      end else if (seq_reg == SEQ_IDLE) begin
        seq_reg <= (addr_reg.offs == CMD_ADDR_A && SHARED_LOW_BUS_LINES_IN == CMD_DATA_A) ? SEQ_ONE : SEQ_IDLE;
      end else if (seq_reg == SEQ_ONE) begin
        seq_reg <= (addr_reg.offs == CMD_ADDR_B && SHARED_LOW_BUS_LINES_IN == CMD_DATA_B) ? SEQ_TWO : SEQ_IDLE;
      end else if (seq_reg == SEQ_TWO) begin
        if (addr_reg.offs == CMD_ADDR_A && SHARED_LOW_BUS_LINES_IN == CMD_DATA_OPEN) begin
          seq_reg <= SEQ_OPEN;
        end else if (addr_reg.offs == CMD_ADDR_A && SHARED_LOW_BUS_LINES_IN == CMD_DATA_LOCK) begin
          seq_reg <= SEQ_IDLE;
          lock_open_reg <= 1'b1;
        end else begin
          seq_reg <= SEQ_IDLE;
        end
      end
    end
  end

  // Locks live apart from the memory path so a bad page cannot touch them
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      lock_reg <= LOCK_RESET;
    end else if (wr_fall & lock_open_reg & (state_reg != ST_PROG)) begin
      lock_reg <= SHARED_LOW_BUS_LINES_IN;
    end
  end

  // ----------------------------------------------------------------
  // Load window and programming sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      state_reg <= ST_IDLE;
      timer_reg <= '0;
      prog_plane_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (wr_rise) begin
            state_reg <= ST_LOAD;
            timer_reg <= TIMER_W'(LOAD_CYCLES - 1);
          end
        end
        ST_LOAD: begin
          if (cancel) begin
            state_reg <= ST_IDLE;
          end else if (wr_rise) begin
            timer_reg <= TIMER_W'(LOAD_CYCLES - 1);
          end else if (start_prog) begin
            state_reg <= ST_PROG;
            timer_reg <= TIMER_W'(PROG_TIME_CYCLES - 1);
            prog_plane_reg <= page_reg[PLANE_BIT-PAGE_AW];
          end else if (load_done) begin
            state_reg <= ST_IDLE;
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
        ST_PROG: begin
          if (timer_reg == '0) begin
            state_reg <= ST_IDLE;
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read path, polling and status outputs
  // ----------------------------------------------------------------
  logic busy_plane_hit;
  logic [7:0] rd_data;

  assign busy_plane_hit = (state_reg == ST_PROG) & (addr_reg.offs[PLANE_BIT] == prog_plane_reg);

  always_comb begin
    rd_data = mem[addr_reg.offs];
    if (busy_plane_hit) begin
      rd_data[TOGGLE_BIT] = toggle_reg;
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      toggle_reg <= 1'b0;
    end else if (rd_rise & busy_plane_hit) begin
      toggle_reg <= ~toggle_reg;
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      SHARED_LOW_BUS_LINES_OUT <= BUS_RESET;
      SHARED_LOW_BUS_LINES_OE_OUT <= 1'b0;
      STANDBY_OUT <= 1'b0;
      PROG_BUSY_OUT <= 1'b0;
      SECTION_LOCK_OUT <= LOCK_RESET;
    end else begin
      SHARED_LOW_BUS_LINES_OE_OUT <= BUS_PHASE_CLK_IN & READ_NOT_WRITE_IN & hit;
      SHARED_LOW_BUS_LINES_OUT <= rd_data;
      STANDBY_OUT <= ~CHIP_ENABLE_IN & ~ADDRESS_LATCH_STROBE_IN;
      PROG_BUSY_OUT <= (state_reg == ST_PROG);
      SECTION_LOCK_OUT <= lock_reg;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence rd_phase_s;
    BUS_PHASE_CLK_IN && READ_NOT_WRITE_IN && hit;
  endsequence

  sequence load_expire_s;
    start_prog ##1 (state_reg == ST_PROG);
  endsequence

  addr_latch_a: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    as_fall |=> addr_reg == {$past(UPPER_ADDRESS_LINES_IN), $past(SHARED_LOW_BUS_LINES_IN)})
    else $error("address not latched at strobe fall");

  read_drive_a: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    rd_phase_s |=> SHARED_LOW_BUS_LINES_OE_OUT)
    else $error("read data not driven");

  no_drive_write_a: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    !READ_NOT_WRITE_IN |=> !SHARED_LOW_BUS_LINES_OE_OUT)
    else $error("bus driven during write");

  byte_capture_a: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    take_byte |=> page_valid_reg[$past(addr_reg.offs[PAGE_AW-1:0])])
    else $error("write byte not captured");

  timer_restart_a: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    wr_rise && state_reg != ST_PROG && !cancel |=> timer_reg == TIMER_W'(LOAD_CYCLES - 1))
    else $error("load timer not restarted");

  prog_entry_a: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    load_expire_s |=> PROG_BUSY_OUT [*2])
    else $error("programming did not start on expiry");

  cancel_load_a: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    cancel |=> state_reg == ST_IDLE && page_valid_reg == '0)
    else $error("control input did not cancel load");

  lock_discard_a: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    wr_fall && lock_reg[addr_reg.offs[SECT_LO +: 3]] && !load_done && !cancel |=> $stable(page_valid_reg))
    else $error("locked section byte accepted");

  guard_block_a: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    wr_fall && GLOBAL_WRITE_GUARD_IN && seq_reg != SEQ_OPEN && !load_done && !cancel |=> $stable(page_valid_reg))
    else $error("guarded write accepted");

  poll_toggle_a: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    rd_rise && busy_plane_hit |=> toggle_reg != $past(toggle_reg))
    else $error("status bit did not alternate");

  standby_a: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    !CHIP_ENABLE_IN && !ADDRESS_LATCH_STROBE_IN |=> STANDBY_OUT)
    else $error("standby not shown");

endmodule // mbe_write_ctrl

`default_nettype wire

// File: core/mbe_pkg.sv
`default_nettype none

package mbe_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int LOAD_WINDOW_US = 100;
  localparam int PROG_TIME_MS = 5;
  localparam int LOAD_WINDOW_CYCLES = (LOAD_WINDOW_US * 1000) / CLK_PERIOD_NS;
  localparam int PROG_CYCLES = (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int TIMER_W = 19;
  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int MEM_AW = 13;
  localparam int MEM_BYTES = 8192;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_AW = 5;
  localparam int PLANE_BIT = 12;
  localparam int SECT_LO = 10;
  localparam int SECTIONS = 8;
  localparam int TOGGLE_BIT = 6;
  // ----------------------------------------------------------------
  // Write guard command sequence
  // ----------------------------------------------------------------
  localparam logic [12:0] CMD_ADDR_A = 13'h1555;
  localparam logic [12:0] CMD_ADDR_B = 13'h0aaa;
  localparam logic [7:0] CMD_DATA_A = 8'haa;
  localparam logic [7:0] CMD_DATA_B = 8'h55;
  localparam logic [7:0] CMD_DATA_OPEN = 8'ha0;
  localparam logic [7:0] CMD_DATA_LOCK = 8'h80;
  localparam logic [1:0] SEQ_IDLE = 2'h0;
  localparam logic [1:0] SEQ_ONE = 2'h1;
  localparam logic [1:0] SEQ_TWO = 2'h2;
  localparam logic [1:0] SEQ_OPEN = 2'h3;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] LOCK_RESET = 8'h00;
  localparam logic [7:0] BUS_RESET = 8'h00;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_PROG = 3'b100
  } mbe_state_t;

  typedef struct packed {
    logic [2:0] region;
    logic [12:0] offs;
  } mbe_addr_t;

endpackage

`default_nettype wire

// File: tb/mbe_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module mbe_host_model (
  // Bus clock
  input wire logic clk,
  // Host bus
  output logic ce,
  output logic strobe,
  output logic phase,
  output logic rnw,
  output logic [7:0] upper,
  output logic [7:0] low,
  input wire logic [7:0] bus_in
);
  initial begin
    ce = 1'b1;
    strobe = 1'b1;
    phase = 1'b0;
    rnw = 1'b1;
    upper = 8'h00;
    low = 8'h00;
  end

  // One bus cycle of six clocks, so bytes stay well inside the load window
  task automatic access(input logic [15:0] a, input logic wr, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    ce <= 1'b1;
    upper <= a[15:8];
    low <= a[7:0];
    @(posedge clk);
    strobe <= 1'b0;
    @(posedge clk);
    // Released lines carry the inverse so a stale byte never reads as valid
    low <= wr ? d : ~a[7:0];
    rnw <= ~wr;
    phase <= 1'b1;
    repeat (2) @(posedge clk);
    q = bus_in;
    phase <= 1'b0;
    @(posedge clk);
    strobe <= 1'b1;
    rnw <= 1'b1;
    low <= ~low;
  endtask

  task automatic standby(input logic on);
    @(posedge clk);
    ce <= ~on;
    strobe <= ~on;
  endtask
endmodule // mbe_host_model

`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
  import mbe_pkg::*;
  // Short counts keep the run small
  localparam int LOADC = 20;
  localparam int PROGC = 50;
  logic clk, rst, wc, guard, ce, strobe, phase, rnw, oe, oe_d, standby, busy;
  logic [2:0] region;
  logic [7:0] upper, host_low, dout, lock, q, q2, d, lk;
  logic [7:0] pg [4];
  logic [7:0] bus;
  logic [15:0] notes [$];
  int mismatches, check_count, cycles, n;

  assign bus = oe ? dout : host_low;

  mbe_host_model u_host (.clk(clk), .ce(ce), .strobe(strobe), .phase(phase), .rnw(rnw), .upper(upper),
    .low(host_low), .bus_in(bus));

  mbe_write_ctrl #(.LOAD_CYCLES(LOADC), .PROG_TIME_CYCLES(PROGC)) u_dut (.CORE_CLK_IN(clk), .SYS_RST_IN(rst),
    .CHIP_ENABLE_IN(ce), .ADDRESS_LATCH_STROBE_IN(strobe), .BUS_PHASE_CLK_IN(phase), .READ_NOT_WRITE_IN(rnw),
    .UPPER_ADDRESS_LINES_IN(upper), .SHARED_LOW_BUS_LINES_IN(bus), .SHARED_LOW_BUS_LINES_OUT(dout),
    .SHARED_LOW_BUS_LINES_OE_OUT(oe), .WRITE_COMPLETION_CONTROL_IN(wc), .GLOBAL_WRITE_GUARD_IN(guard),
    .REGION_BASE_IN(region), .STANDBY_OUT(standby), .PROG_BUSY_OUT(busy), .SECTION_LOCK_OUT(lock));

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] v);
    u_host.access({region, a}, 1'b1, v, q);
  endtask

  // A mask of zero notes a read whose data is not predictable
  task automatic rd(input logic [12:0] a, input logic [7:0] v, input logic [7:0] m);
    notes.push_back({m, v});
    u_host.access({region, a}, 1'b0, 8'h00, q);
  endtask

  task automatic cmd(input logic [7:0] last);
    wr(CMD_ADDR_A, CMD_DATA_A);
    wr(CMD_ADDR_B, CMD_DATA_B);
    wr(CMD_ADDR_A, last);
  endtask

  task automatic wait_for(input logic lvl, input int lim);
    n = 0;
    while (busy !== lvl && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Read monitor and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (oe === 1'b1 && oe_d !== 1'b1) begin
      if (notes.size() == 0) begin
        check({7'h00, oe}, 8'h00, "unexpected read drive");
      end else begin
        check(dout & notes[0][15:8], notes[0][7:0] & notes[0][15:8], "read data");
        notes.pop_front();
      end
    end
    oe_d <= oe;
    if (cycles == 5000) begin
      mismatches++;
      $display("MISMATCH at %0t: run did not finish", $time);
      final_report();
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    wc = 1'b0;
    guard = 1'b0;
    oe_d = 1'b0;
    mismatches = 0;
    check_count = 0;
    cycles = 0;
    n = $urandom(32'h52231660);
    region = 3'($urandom);
    for (int i = 0; i < 4; i++) pg[i] = 8'($urandom);
    d = 8'($urandom);
    lk = (8'($urandom) | 8'h01) & 8'hfd;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wr(13'h0040, pg[0]);
    wr(13'h005f, pg[1]);
    wr(13'h0041, pg[2]);
    wr(13'h0040, pg[3]);
    wait_for(1'b1, LOADC + 10);
    check(8'(n >= LOADC - 2 && n <= LOADC + 2), 8'h01, "load window");
    wait_for(1'b0, PROGC + 10);
    check(8'(n >= PROGC - 2 && n <= PROGC + 2), 8'h01, "programming time");
    rd(13'h0040, pg[3], 8'hff);
    rd(13'h005f, pg[1], 8'hff);
    rd(13'h0041, pg[2], 8'hff);
    $display("Test page write done");
    wr(13'h1234, d);
    wait_for(1'b1, LOADC + 10);
    wait_for(1'b0, PROGC + 10);
    wr(13'h0100, pg[0]);
    wait_for(1'b1, LOADC + 10);
    rd(13'h1234, d, 8'hff);
    rd(13'h0100, 8'h00, 8'h00);
    q2 = q;
    rd(13'h0100, 8'h00, 8'h00);
    check({7'h00, q[TOGGLE_BIT] ^ q2[TOGGLE_BIT]}, 8'h01, "toggle bit");
    wait_for(1'b0, PROGC + 10);
    rd(13'h0100, pg[0], 8'hff);
    $display("Test plane overlap done");
    wr(13'h0200, d);
    wc <= 1'b1;
    wait_for(1'b1, LOADC + 10);
    check({7'h00, busy}, 8'h00, "cancelled load programmed");
    wc <= 1'b0;
    $display("Test cancel done");
    guard <= 1'b1;
    wr(13'h0300, d);
    wait_for(1'b1, LOADC + 10);
    check({7'h00, busy}, 8'h00, "guarded write programmed");
    cmd(CMD_DATA_OPEN);
    wr(13'h0300, pg[1]);
    wait_for(1'b1, LOADC + 10);
    check({7'h00, busy}, 8'h01, "opened write idle");
    wait_for(1'b0, PROGC + 10);
    rd(13'h0300, pg[1], 8'hff);
    cmd(CMD_DATA_LOCK);
    wr(13'h0000, lk);
    wait_for(1'b1, LOADC + 10);
    wait_for(1'b0, PROGC + 10);
    check(lock, lk, "lock register");
    guard <= 1'b0;
    wr(13'h0040, d);
    wait_for(1'b1, LOADC + 10);
    check({7'h00, busy}, 8'h00, "locked section programmed");
    wr(13'h0400, d);
    wait_for(1'b1, LOADC + 10);
    check({7'h00, busy}, 8'h01, "open section idle");
    wait_for(1'b0, PROGC + 10);
    rd(13'h0400, d, 8'hff);
    rd(13'h0040, pg[3], 8'hff);
    $display("Test protection done");
    u_host.standby(1'b1);
    repeat (2) @(posedge clk);
    check({7'h00, standby}, 8'h01, "standby");
    u_host.standby(1'b0);
    repeat (2) @(posedge clk);
    check({7'h00, standby}, 8'h00, "standby exit");
    u_host.access({region + 3'h1, 13'h0040}, 1'b0, 8'h00, q);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    check(lock, LOCK_RESET, "lock after reset");
    $display("Test standby and decode done");
    final_report();
  end
endmodule // tb

`default_nettype wire
